// ---- rtl/rhptl_link.v ----
// Telegram framer, result formatter and switching outputs of the sensor.
`include "rhptl_map.vh"

// Small FIFO between the response builder and the transmitter.
module rhptl_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  input wire sys_clk,
  input wire nrst,
  input wire clk_en,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt != D[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at the depth so that a depth not a power of two works.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wp <= (wp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Storage has no reset; only written entries are ever read.
  always @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// Device side of the serial telegram link with the position outputs.
module rhptl_link #(
  parameter PW = 24,
  parameter FIFO_DEPTH = 4
) (
  input wire sys_clk,
  input wire nrst,
  input wire clk_en,
  input wire rx_pin,
  output reg tx_pin,
  input wire cycle_stop_pin,
  input wire relative_pin,
  input wire setup_req,
  input wire cfg_wr,
  input wire [2:0] cfg_node_address,
  input wire [2:0] cfg_rate_sel,
  input wire cfg_continuous,
  input wire [PW-1:0] cfg_origin_shift_x,
  input wire [PW-1:0] cfg_origin_shift_y,
  input wire [PW-1:0] cfg_store_shift_x,
  input wire [PW-1:0] cfg_store_shift_y,
  input wire [PW-1:0] cfg_tol_x,
  input wire [PW-1:0] cfg_tol_y,
  input wire diag_req,
  output reg diag_ack,
  input wire meas_valid,
  input wire [PW-1:0] meas_x,
  input wire [PW-1:0] meas_y,
  input wire [PW-1:0] meas_z,
  input wire meas_warn,
  input wire meas_no_hole,
  input wire meas_err,
  input wire [6:0] meas_fault,
  output reg out_neg_x,
  output reg out_pos_x,
  output reg out_neg_y,
  output reg out_pos_y,
  output reg setup_mode,
  output wire cycle_stopped,
  output reg [2:0] node_address,
  output reg req_error
);
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;

  reg [2:0] rate_sel;
  reg continuous;
  reg [PW-1:0] origin_x, origin_y, store_x, store_y, tol_x, tol_y;
  reg rx_s1, rx_s2, stop_s1, stop_s2, rel_s1, rel_s2;

  // Configuration is frozen outside setup mode; setup is left at reset.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      setup_mode <= 1'b0;
      diag_ack <= 1'b0;
      node_address <= `RH_ADDR_DEF;
      rate_sel <= `RH_RATE_DEF;
      continuous <= 1'b0;
      origin_x <= {PW{1'b0}};
      origin_y <= {PW{1'b0}};
      store_x <= {PW{1'b0}};
      store_y <= {PW{1'b0}};
      tol_x <= {PW{1'b0}};
      tol_y <= {PW{1'b0}};
    end else if (clk_en) begin
      setup_mode <= setup_req;
      diag_ack <= setup_mode & diag_req;
      if (setup_mode && cfg_wr) begin
        node_address <= cfg_node_address;
        rate_sel <= cfg_rate_sel;
        continuous <= cfg_continuous;
        origin_x <= cfg_origin_shift_x;
        origin_y <= cfg_origin_shift_y;
        store_x <= cfg_store_shift_x;
        store_y <= cfg_store_shift_y;
        tol_x <= cfg_tol_x;
        tol_y <= cfg_tol_y;
      end
    end
  end

  // Pins from outside pass two flip-flops; the line idles high.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
      rel_s1 <= 1'b0;
      rel_s2 <= 1'b0;
    end else if (clk_en) begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      stop_s1 <= cycle_stop_pin;
      stop_s2 <= stop_s1;
      rel_s1 <= relative_pin;
      rel_s2 <= rel_s1;
    end
  end

  // Clocks per bit; unused codes fall back to the default rate.
  function [15:0] bit_div;
    input [2:0] sel;
    reg [31:0] q;
    begin
      case (sel)
        `RH_RATE_9600: q = `RH_CLK_HZ / `RH_BAUD_0;
        `RH_RATE_19200: q = `RH_CLK_HZ / `RH_BAUD_1;
        `RH_RATE_38400: q = `RH_CLK_HZ / `RH_BAUD_2;
        `RH_RATE_57600: q = `RH_CLK_HZ / `RH_BAUD_3;
        `RH_RATE_230400: q = `RH_CLK_HZ / `RH_BAUD_5;
        default: q = `RH_CLK_HZ / `RH_BAUD_4;
      endcase
      // Every quotient fits sixteen bits, so the upper half is always zero.
      bit_div = q[15:0];
    end
  endfunction

  wire [15:0] div = bit_div(rate_sel);

  reg [1:0] rx_state;
  reg [15:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [8:0] rx_sh;
  reg rx_stb;
  reg rx_good;

  // Receiver samples mid-bit; a false start bit returns to idle.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_stb <= 1'b0;
      rx_good <= 1'b0;
    end else if (clk_en) begin
      rx_stb <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (!rx_s2) begin
            rx_state <= RX_START;
            rx_cnt <= {1'b0, div[15:1]};
          end
        end
        RX_START: begin
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else if (!rx_s2) begin
            // The sampling edge itself counts, so reload one short of div.
            rx_state <= RX_BITS;
            rx_cnt <= div - 16'h0001;
            rx_bit <= 4'h0;
          end else begin
            rx_state <= RX_IDLE;
          end
        end
        RX_BITS: begin
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else if (rx_bit == `RH_RX_LAST) begin
            // Stop bit sampled; even parity makes the nine bits xor to 0.
            rx_state <= RX_IDLE;
            rx_stb <= 1'b1;
            rx_good <= rx_s2 & ~(^rx_sh);
          end else begin
            rx_sh <= {rx_s2, rx_sh[8:1]};
            rx_bit <= rx_bit + 4'h1;
            rx_cnt <= div - 16'h0001;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  reg have_first;
  reg first_ok;
  reg [7:0] first;
  reg stop_cmd;
  reg send_req;
  wire pair_ok = first_ok & rx_good & (rx_sh[7:0] == ~first)
    & first[`RH_DIR_BIT]
    & (first[`RH_ADDR_HI:0] == node_address);

  // Characters pair strictly: each second one closes the request.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      have_first <= 1'b0;
      first_ok <= 1'b0;
      first <= 8'h00;
      stop_cmd <= 1'b0;
      send_req <= 1'b0;
      req_error <= 1'b0;
    end else if (clk_en) begin
      send_req <= 1'b0;
      req_error <= 1'b0;
      if (rx_stb) begin
        have_first <= ~have_first;
        if (!have_first) begin
          first <= rx_sh[7:0];
          first_ok <= rx_good;
        end else if (!pair_ok) begin
          req_error <= 1'b1;
        end else if (first[`RH_CMD_HI:`RH_CMD_LO] == `RH_CMD_DATA) begin
          send_req <= 1'b1;
        end else if (first[`RH_DIR_BIT:`RH_CMD_LO] == `RH_OP_STOP) begin
          stop_cmd <= 1'b1;
        end else if (first[`RH_DIR_BIT:`RH_CMD_LO] == `RH_OP_RUN) begin
          stop_cmd <= 1'b0;
        end
      end
    end
  end

  // Either the stop command or the stop input halts measurement.
  assign cycle_stopped = stop_cmd | stop_s2;

  // Target point in sensor coordinates (x right, y up), two extra bits.
  wire [PW+1:0] zx = {{2{origin_x[PW-1]}}, origin_x};
  wire [PW+1:0] zy = {{2{origin_y[PW-1]}}, origin_y};
  wire [PW+1:0] sx = rel_s2 ? {{2{store_x[PW-1]}}, store_x}
    : {(PW+2){1'b0}};
  wire [PW+1:0] sy = rel_s2 ? {{2{store_y[PW-1]}}, store_y}
    : {(PW+2){1'b0}};
  wire [PW+1:0] tgt_x = sx - zx;
  wire [PW+1:0] tgt_y = sy - zy;
  wire [PW+1:0] dev_x = {{2{meas_x[PW-1]}}, meas_x} - tgt_x;
  wire [PW+1:0] dev_y = {{2{meas_y[PW-1]}}, meas_y} - tgt_y;
  wire [PW+1:0] mag_x = dev_x[PW+1] ? (~dev_x + 1'b1) : dev_x;
  wire [PW+1:0] mag_y = dev_y[PW+1] ? (~dev_y + 1'b1) : dev_y;
  wire [PW+1:0] tx_lim = {2'b00, tol_x};
  wire [PW+1:0] ty_lim = {2'b00, tol_y};

  reg res_sx, res_sy, res_warn, res_no_hole, res_err, res_new;
  reg [PW-1:0] res_x, res_y, res_z;
  reg [6:0] res_cnt, res_fault;

  // Results update only while running; a halt keeps the last set.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {res_sx, res_sy, res_warn, res_no_hole, res_err} <= 5'h00;
      res_new <= 1'b0;
      res_x <= {PW{1'b0}};
      res_y <= {PW{1'b0}};
      res_z <= {PW{1'b0}};
      res_cnt <= 7'h00;
      res_fault <= 7'h00;
      {out_neg_x, out_pos_x, out_neg_y, out_pos_y} <= 4'hf;
    end else if (clk_en) begin
      res_new <= 1'b0;
      if (meas_valid && !cycle_stopped) begin
        res_new <= 1'b1;
        res_sx <= dev_x[PW+1];
        res_sy <= dev_y[PW+1];
        // Magnitudes beyond the field saturate rather than wrap.
        res_x <= (mag_x[PW+1:PW] != 2'b00) ? {PW{1'b1}} : mag_x[PW-1:0];
        res_y <= (mag_y[PW+1:PW] != 2'b00) ? {PW{1'b1}} : mag_y[PW-1:0];
        res_z <= meas_z;
        res_warn <= meas_warn;
        res_no_hole <= meas_no_hole;
        res_err <= meas_err;
        res_fault <= {1'b0, meas_fault[5:0]};
        res_cnt <= (res_cnt == `RH_CNT_MAX) ? 7'h00 : res_cnt + 7'h01;
        // Outside the band only the far-side output drops.
        out_neg_x <= dev_x[PW+1] | (mag_x <= tx_lim);
        out_pos_x <= ~dev_x[PW+1] | (mag_x <= tx_lim);
        out_neg_y <= dev_y[PW+1] | (mag_y <= ty_lim);
        out_pos_y <= ~dev_y[PW+1] | (mag_y <= ty_lim);
      end
    end
  end

  // One 24-bit field with its sign, spread over four seven-bit bytes.
  function [31:0] fld;
    input sgn;
    input [23:0] v;
    begin
      fld = {4'h0, sgn, v[23:21], 1'b0, v[20:14],
        1'b0, v[13:7], 1'b0, v[6:0]};
    end
  endfunction

  wire [119:0] body = {1'b0, node_address, 1'b0, res_warn,
    res_no_hole, res_err, fld(res_sx, res_x), fld(res_sy, res_y),
    fld(1'b0, res_z), 1'b0, res_cnt, 1'b0, res_fault};
  wire [7:0] xacc [0:`RH_BODY_BYTES];
  assign xacc[0] = 8'h00;

  // Check byte folds the fifteen body characters one by one.
  genvar gi;
  generate
    for (gi = 0; gi < `RH_BODY_BYTES; gi = gi + 1) begin : g_xor
      assign xacc[gi+1] = xacc[gi] ^ body[gi*8 +: 8];
    end
  endgenerate

  reg pend, busy;
  reg [4:0] idx;
  reg [135:0] frame;
  wire f_ready;
  wire f_push = busy & f_ready;
  wire trig = send_req | (continuous & res_new);

  // Builder snapshots the frame, then feeds it to the FIFO with stalls.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      busy <= 1'b0;
      idx <= 5'h00;
      frame <= {136{1'b0}};
    end else if (clk_en) begin
      // A trigger during the start is kept: set wins over clear.
      pend <= (pend & busy) | trig;
      if (!busy && pend) begin
        busy <= 1'b1;
        idx <= 5'h00;
        frame <= {body, xacc[`RH_BODY_BYTES], `RH_TRAILER};
      end else if (f_push) begin
        frame <= {frame[127:0], 8'h00};
        idx <= idx + 5'h01;
        if (idx == `RH_RESP_LAST) begin
          busy <= 1'b0;
        end
      end
    end
  end

  wire [7:0] t_data;
  wire t_valid;
  reg [10:0] tx_sh;
  reg [3:0] tx_bit;
  reg [15:0] tx_cnt;
  reg tx_busy;
  wire t_take = t_valid & ~tx_busy;

  rhptl_fifo #(
    .W(8),
    .D(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .in_data(frame[135:128]),
    .in_valid(busy),
    .in_ready(f_ready),
    .out_data(t_data),
    .out_valid(t_valid),
    .out_ready(t_take)
  );

  // Transmitter sends start, data LSB first, even parity, stop.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_pin <= 1'b1;
      tx_sh <= {11{1'b1}};
      tx_bit <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_busy <= 1'b0;
    end else if (clk_en) begin
      if (t_take) begin
        tx_busy <= 1'b1;
        tx_pin <= 1'b0;
        tx_sh <= {1'b1, 1'b1, ^t_data, t_data};
        tx_bit <= 4'h0;
        tx_cnt <= div - 16'h0001;
      end else if (tx_busy) begin
        if (tx_cnt != 16'h0000) begin
          tx_cnt <= tx_cnt - 16'h0001;
        end else if (tx_bit == `RH_FRAME_BITS) begin
          tx_busy <= 1'b0;
        end else begin
          tx_pin <= tx_sh[0];
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_bit <= tx_bit + 4'h1;
          tx_cnt <= div - 16'h0001;
        end
      end
    end
  end
endmodule

// ---- inc/rhptl_map.vh ----
// Constants for the rack hole position telegram link.
`ifndef RHPTL_MAP_VH
`define RHPTL_MAP_VH
// System clock rate in hertz.
`define RH_CLK_HZ 40000000
// Line rates in bit/s, selected by a three-bit rate code.
`define RH_BAUD_0 9600
`define RH_BAUD_1 19200
`define RH_BAUD_2 38400
`define RH_BAUD_3 57600
`define RH_BAUD_4 115200
`define RH_BAUD_5 230400
`define RH_RATE_9600 3'h0
`define RH_RATE_19200 3'h1
`define RH_RATE_38400 3'h2
`define RH_RATE_57600 3'h3
`define RH_RATE_115200 3'h4
`define RH_RATE_230400 3'h5
// Reset values of configuration.
`define RH_RATE_DEF 3'h4
`define RH_ADDR_DEF 3'h0
// Request character fields.
`define RH_DIR_BIT 7
`define RH_CMD_HI 6
`define RH_CMD_LO 3
`define RH_ADDR_HI 2
`define RH_CMD_DATA 4'h2
`define RH_OP_STOP 5'h1a
`define RH_OP_RUN 5'h1b
// Character framing: start, eight data, parity, stop.
`define RH_FRAME_BITS 4'ha
`define RH_RX_LAST 4'h9
// Response framing.
`define RH_RESP_LAST 5'h10
`define RH_BODY_BYTES 15
`define RH_TRAILER 8'haa
// Result counter wraps after this value.
`define RH_CNT_MAX 7'h63
`endif

// ---- bench/rhptl_plc.sv ----
// Controller model that sends request pairs and collects response characters.
module rhptl_plc #(
  parameter int BIT = 173
) (
  input wire logic sys_clk,
  output logic to_dut,
  input wire logic from_dut,
  output logic got,
  output logic [7:0] got_byte,
  output logic got_par_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line idles at mark level, as a terminated differential pair does.
  initial begin
    to_dut = 1'b1;
    got = 1'b0;
    got_byte = 8'h00;
    got_par_ok = 1'b0;
  end

  // One character: start, eight data bits LSB first, even parity, stop.
  task automatic send_char(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad, d, 1'b0};
    @(posedge sys_clk);
    #2;
    for (int i = 0; i < 11; i++) begin
      to_dut = f[i];
      repeat (BIT) @(posedge sys_clk);
      #2;
    end
  endtask

  // A request is always two characters sent back to back.
  task automatic send_pair(input logic [7:0] a, b, input logic bad);
    send_char(a, bad);
    send_char(b, 1'b0);
  endtask

  // Receiver samples mid-bit; the flag is raised off the edge to avoid races.
  always begin
    logic [8:0] sh;
    @(negedge from_dut);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge sys_clk);
      sh[i] = from_dut;
    end
    repeat (BIT) @(posedge sys_clk);
    #2;
    got_byte = sh[7:0];
    got_par_ok = ~^sh & from_dut;
    got = 1'b1;
    @(posedge sys_clk);
    #2;
    got = 1'b0;
  end
endmodule

// ---- bench/rhptl_link_sva.sv ----
// Concurrent checks on the ports of the telegram link.
module rhptl_link_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tx_pin,
  input wire logic diag_req,
  input wire logic diag_ack,
  input wire logic meas_valid,
  input wire logic cycle_stopped,
  input wire logic out_neg_x,
  input wire logic out_pos_x,
  input wire logic out_neg_y,
  input wire logic out_pos_y,
  input wire logic setup_mode,
  input wire logic [2:0] node_address,
  input wire logic req_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // A falling line level must be followed by eight more cycles low.
  sequence s_line_fall;
    tx_pin ##1 !tx_pin;
  endsequence

  chk_auto_start: assert property ($rose(nrst) |-> !setup_mode)
    else $error("setup mode active right after reset");
  chk_reset_idle: assert property (
    $rose(nrst) |-> tx_pin && !req_error)
    else $error("line not idle after reset");
  chk_diag_gate: assert property (
    diag_req |=> diag_ack == $past(setup_mode))
    else $error("diagnostic answer outside setup mode");
  chk_addr_hold: assert property (
    !setup_mode |=> $stable(node_address))
    else $error("node address changed in automatic mode");
  chk_outs_hold: assert property (
    (!meas_valid || cycle_stopped) |=>
    $stable({out_neg_x, out_pos_x, out_neg_y, out_pos_y}))
    else $error("axis outputs moved without an accepted result");
  chk_err_pulse: assert property (req_error |=> !req_error)
    else $error("reject flag longer than one cycle");
  chk_bit_width: assert property (s_line_fall |=> (!tx_pin) [*8])
    else $error("low bit on line too short");
  chk_x_pair: assert property (out_neg_x || out_pos_x)
    else $error("horizontal outputs both low");
  chk_y_pair: assert property (out_neg_y || out_pos_y)
    else $error("vertical outputs both low");
endmodule

bind rhptl_link rhptl_link_sva u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .tx_pin(tx_pin), .diag_req(diag_req),
  .diag_ack(diag_ack), .meas_valid(meas_valid),
  .cycle_stopped(cycle_stopped), .out_neg_x(out_neg_x),
  .out_pos_x(out_pos_x), .out_neg_y(out_neg_y), .out_pos_y(out_pos_y),
  .setup_mode(setup_mode), .node_address(node_address),
  .req_error(req_error)
);

// ---- bench/rhptl_link_tb.sv ----
// Self-checking bench for the telegram link with a controller model.
module rhptl_link_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OX = 100, OY = -50, SX = -300, SY = 250, TOL = 200;
  logic sys_clk = 0, nrst = 0, rx_pin, tx_pin, relative_pin = 0;
  logic setup_req = 0, cfg_wr = 0, diag_req = 0, diag_ack, meas_valid = 0;
  logic [23:0] meas_x = 0, meas_y = 0, meas_z = 0;
  logic meas_warn = 0, meas_no_hole = 0, meas_err = 0;
  logic [6:0] meas_fault = 0;
  logic stop_pin = 0, cont = 0;
  logic [23:0] ox = 24'(OX), oy = 24'(OY), sx = 24'(SX), sy = 24'(SY);
  logic [23:0] tl = 24'(TOL);
  logic out_neg_x, out_pos_x, out_neg_y, out_pos_y, setup_mode;
  logic cycle_stopped, req_error, got, got_par_ok;
  logic [2:0] node_address;
  logic [7:0] got_byte, xr, exp_q[$];
  logic [3:0] o;
  int seed = 51847, err_total = 0, compares = 0, cyc = 0, err_seen = 0;
  int dx, dy, tx, ty, z, fl, z0, f0;

  rhptl_link u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .cycle_stop_pin(stop_pin),
    .relative_pin(relative_pin), .setup_req(setup_req), .cfg_wr(cfg_wr),
    .cfg_node_address(3'h5), .cfg_rate_sel(3'h5), .cfg_continuous(cont),
    .cfg_origin_shift_x(ox), .cfg_origin_shift_y(oy),
    .cfg_store_shift_x(sx), .cfg_store_shift_y(sy),
    .cfg_tol_x(tl), .cfg_tol_y(tl), .diag_req(diag_req),
    .diag_ack(diag_ack), .meas_valid(meas_valid), .meas_x(meas_x),
    .meas_y(meas_y), .meas_z(meas_z), .meas_warn(meas_warn),
    .meas_no_hole(meas_no_hole), .meas_err(meas_err),
    .meas_fault(meas_fault), .out_neg_x(out_neg_x), .out_pos_x(out_pos_x),
    .out_neg_y(out_neg_y), .out_pos_y(out_pos_y), .setup_mode(setup_mode),
    .cycle_stopped(cycle_stopped), .node_address(node_address),
    .req_error(req_error));
  rhptl_plc u_plc (.sys_clk(sys_clk), .to_dut(rx_pin), .from_dut(tx_pin),
    .got(got), .got_byte(got_byte), .got_par_ok(got_par_ok));

  // Clock at 40 MHz.
  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Body characters also feed the running check byte.
  task automatic put(input logic [7:0] b);
    exp_q.push_back(b);
    xr = xr ^ b;
  endtask

  // Sign bit and top three magnitude bits, then seven bits per character.
  task automatic put_axis(input int v);
    logic [23:0] m;
    m = 24'(v < 0 ? -v : v);
    put({4'h0, v < 0, m[23:21]});
    put({1'b0, m[20:14]});
    put({1'b0, m[13:7]});
    put({1'b0, m[6:0]});
  endtask

  // One whole response frame: header, three axes, counter, faults, check, trailer.
  task automatic expect_frame(input int ex, ey, ez, ef, input logic [7:0] n);
    xr = 8'h00;
    put({4'h5, 1'b0, 3'(ef >> 7)});
    put_axis(ex);
    put_axis(ey);
    put_axis(ez);
    put(n);
    put({2'h0, 6'(ef)});
    exp_q.push_back(xr);
    exp_q.push_back(8'haa);
  endtask

  // Wait for every noted character to come back, within 40000 cycles, a little over one frame time.
  task automatic drain;
    for (int k = 0; k < 40000 && exp_q.size() > 0; k++) @(posedge sys_clk);
    check(24'(exp_q.size()), 24'h0);
  endtask

  task automatic measure(input int mx, my);
    @(posedge sys_clk);
    #2;
    meas_x = 24'(mx);
    meas_y = 24'(my);
    z = $random(seed) & 32'hfffff;
    fl = $random(seed);
    meas_z = 24'(z);
    {meas_warn, meas_no_hole, meas_err, meas_fault} = 10'(fl);
    meas_valid = 1'b1;
    @(posedge sys_clk);
    #2;
    meas_valid = 1'b0;
  endtask

  // Every received character is taken against the oldest expectation.
  always @(posedge sys_clk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check(24'h1, 24'h0);
      else check(24'(got_byte), 24'(exp_q.pop_front()));
      check(24'(got_par_ok), 24'h1);
    end
    if (req_error === 1'b1) err_seen++;
    cyc++;
    if (cyc == 96000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    #2 nrst = 1'b1;
    @(posedge sys_clk);
    #2 check(24'({tx_pin, o_all(), setup_mode, node_address}), 24'h1f0);
    cfg_wr = 1'b1;
    diag_req = 1'b1;
    @(posedge sys_clk);
    #2 cfg_wr = 1'b0;
    @(posedge sys_clk);
    #2 check(24'({setup_mode, diag_ack, node_address}), 24'h0);
    setup_req = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2 cfg_wr = 1'b1;
    @(posedge sys_clk);
    #2 cfg_wr = 1'b0;
    check(24'({setup_mode, diag_ack, node_address}), 24'h1d);
    setup_req = 1'b0;
    diag_req = 1'b0;
    // Alternate the offset input; two cases sit exactly on the band edge.
    for (int i = 0; i < 6; i++) begin
      relative_pin = i[0];
      repeat (4) @(posedge sys_clk);
      tx = (i[0] ? SX : 0) - OX;
      ty = (i[0] ? SY : 0) - OY;
      dx = (i == 2) ? TOL : $random(seed) % 600;
      dy = (i == 3) ? -TOL : $random(seed) % 600;
      measure(dx + tx, dy + ty);
      check(24'(o_all()), 24'({dx <= TOL, dx >= -TOL, dy <= TOL, dy >= -TOL}));
    end
    // Keep the last accepted result; refused measurements redraw z and fl.
    o = o_all();
    z0 = z;
    f0 = fl;
    u_plc.send_pair(8'hd5, 8'h2a, 1'b0);
    check(24'(cycle_stopped), 24'h1);
    measure(-5000, 5000);
    check(24'(o_all()), 24'(o));
    u_plc.send_pair(8'hdd, 8'h22, 1'b0);
    check(24'(cycle_stopped), 24'h0);
    u_plc.send_pair(8'h95, 8'h6b, 1'b0);
    u_plc.send_pair(8'h95, 8'h6a, 1'b1);
    check(24'(err_seen), 24'h2);
    u_plc.send_pair(8'h94, 8'h6b, 1'b0);
    // Continuous mode halted by the input still answers with the last result.
    setup_req = 1'b1;
    cont = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2 cfg_wr = 1'b1;
    @(posedge sys_clk);
    #2 cfg_wr = 1'b0;
    setup_req = 1'b0;
    stop_pin = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 check(24'(cycle_stopped), 24'h1);
    measure(-5000, 5000);
    check(24'(o_all()), 24'(o));
    expect_frame(dx, dy, z0, f0, 8'h06);
    u_plc.send_pair(8'h95, 8'h6a, 1'b0);
    drain();
    // Running again, an accepted result streams out with no request.
    stop_pin = 1'b0;
    repeat (3) @(posedge sys_clk);
    measure(dx + tx, dy + ty);
    expect_frame(dx, dy, z, fl, 8'h07);
    drain();
    finish_test();
  end

  function automatic logic [3:0] o_all();
    return {out_neg_x, out_pos_x, out_neg_y, out_pos_y};
  endfunction
endmodule
